/* File: src/cache_tlb_array_test_access.sv */
// Test access to cache tag/data arrays and translation CACHE_TAG_CAM_PORT/attribute/physical arrays
module cache_tlb_array_test_access (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          rstn,
    // Test mode select
    input  wire cache_tlb_test_pkg::test_mode_e mode,
    // Test bus request and answer
    input  wire cache_tlb_test_pkg::tb_req_s    req,
    output      cache_tlb_test_pkg::tb_resp_s   resp
);
    import cache_tlb_test_pkg::*;

    // =========================================================================
    // Storage
    // Cache tag CACHE_TAG_CAM_PORT holds {tag[31:7], segment[1:0]}; flag bits live in vectors
    logic [26:0] ctag   [CSEG*CLINE];
    logic [31:0] cdata  [CSEG*CLINE*CWORD];
    logic [CSEG*CLINE-1:0] cvalid_r;
    logic [CSEG*CLINE-1:0] cde_r;
    logic [CSEG*CLINE-1:0] cdo_r;
    logic [CSEG*CLINE-1:0] cwb_r;
    logic [21:0] ttag   [TLBN];
    logic [3:0]  tsize  [TLBN];
    logic [21:0] tattr  [TLBN];
    logic [25:0] tphys  [TLBN];
    logic [TLBN-1:0] tvalid_r;
    logic [TLBN-1:0] tpres_r;

    // Pointers and small registers
    logic [5:0]  cidx_r;
    logic [1:0]  cseg_r;
    logic [2:0]  cword_r;
    logic [6:0]  replacement_shift_register_r;
    logic [31:0] cmres_r;
    logic [5:0]  tidx_r;
    logic [5:0]  tidx2_r;
    logic        pair_sel_r;
    logic [31:0] dac_r;
    logic [31:0] lock_r;
    logic [31:0] tmres_r;
    logic [2:0]  tfault_r;
    tb_resp_s    resp_r;
    tb_resp_s    resp_nxt;

    // =========================================================================
    // Decode
    logic       acc;
    logic       bst;
    logic [5:0] loc;
    logic       c_on;
    logic       t_on;
    logic       c_cam, c_ram, c_match, c_inv_all, c_dirty, c_victim, c_inv_one;
    logic       t_inv_one, t_match, t_cam, t_attr, t_phys, t_pair;
    logic       t_dac, t_lock, t_inv_all;
    logic       attr_acc, phys_acc, legal;

    assign acc  = req.wr | req.rd;
    assign loc  = req.addr[5:0];
    assign bst  = req.addr[ADDR_W-1:BURST_LSB] != 3'h0;
    assign c_on = mode == MODE_CACHE;
    assign t_on = mode == MODE_TLB;

    // Burst-capable locations accept any burst base; the rest only base zero
    assign c_cam     = acc & c_on & (loc == LOC_C_CAM);
    assign c_ram     = acc & c_on & (loc == LOC_C_RAM);
    assign c_match   = acc & c_on & ~bst & (loc == LOC_C_MATCH);
    assign c_inv_all = req.wr & c_on & ~bst & (loc == LOC_C_INV_ALL);
    assign c_dirty   = req.wr & c_on & ~bst & (loc == LOC_C_DIRTY);
    assign c_victim  = req.wr & c_on & ~bst & (loc == LOC_C_VICTIM);
    assign c_inv_one = req.wr & c_on & ~bst & (loc == LOC_C_INV_ONE);
    assign t_inv_one = req.wr & t_on & ~bst & (loc == LOC_T_INV_ONE);
    assign t_match   = acc & t_on & ~bst & (loc == LOC_T_MATCH);
    assign t_cam     = acc & t_on & (loc == LOC_T_CAM);
    assign t_attr    = acc & t_on & (loc == LOC_T_ATTR);
    assign t_phys    = acc & t_on & (loc == LOC_T_PHYS);
    assign t_pair    = acc & t_on & (loc == LOC_T_PAIR);
    assign t_dac     = acc & t_on & ~bst & (loc == LOC_T_DAC);
    assign t_lock    = acc & t_on & ~bst & (loc == LOC_T_LOCK);
    assign t_inv_all = req.wr & t_on & ~bst & (loc == LOC_T_INV_ALL);

    // The paired location alternates attribute beat, then physical beat
    assign attr_acc = t_attr | (t_pair & ~pair_sel_r);
    assign phys_acc = t_phys | (t_pair & pair_sel_r);

    assign legal = c_cam | c_ram | c_match | c_inv_all | c_dirty | c_victim | c_inv_one
                 | t_inv_one | t_match | t_cam | attr_acc | phys_acc | t_dac | t_lock
                 | t_inv_all;

    // =========================================================================
    // Cache entry selection
    logic [7:0]  cent;
    logic [10:0] cdi;
    logic [24:0] wtag_c;
    logic [1:0]  wseg_c;
    logic [2:0]  wword_c;

    assign cent    = {cseg_r, cidx_r};
    assign cdi     = {cseg_r, cidx_r, cword_r};
    assign wtag_c  = req.wdata[31:C_TAG_LSB];
    assign wseg_c  = req.wdata[C_TAG_LSB-1:C_SEG_LSB];
    assign wword_c = req.wdata[C_SEG_LSB-1:C_WORD_LSB];

    // Cache tag compare within the addressed segment, one comparator per line
    logic [CLINE-1:0] cmatch;
    genvar gi;
    generate
        for (gi = 0; gi < CLINE; gi++) begin : g_cmatch
            assign cmatch[gi] = cvalid_r[{wseg_c, 6'(gi)}]
                              & (ctag[{wseg_c, 6'(gi)}][26:2] == wtag_c);
        end
    endgenerate

    // Lowest matching line wins; a healthy array holds at most one
    logic [5:0] chit_idx;
    logic       chit;
    always_comb begin
        chit_idx = 6'h00;
        chit     = 1'b0;
        for (int i = CLINE - 1; i >= 0; i--) begin
            if (cmatch[i]) begin
                chit_idx = 6'(i);
                chit     = 1'b1;
            end
        end
    end

    // =========================================================================
    // Translation compare; the CACHE_TAG_CAM_PORT size code widens the ignored low tag bits
    function automatic logic [21:0] size_mask(input logic [3:0] c);
        size_mask = {12'h000, {4{c[3]}}, {2{c[2]}}, {2{c[1]}}, {2{c[0]}}};
    endfunction

    // One-hot permission bits to two-bit permission code
    function automatic logic [1:0] ap_decode(input logic [3:0] a);
        ap_decode = {a[3] | a[2], a[3] | a[1]};
    endfunction

    logic [21:0]     wtag_t;
    logic [TLBN-1:0] tmatch;
    assign wtag_t = req.wdata[31:T_TAG_LSB];

    generate
        for (gi = 0; gi < TLBN; gi++) begin : g_tmatch
            assign tmatch[gi] = tvalid_r[gi]
                              & (((ttag[gi] ^ wtag_t) & ~size_mask(tsize[gi])) == 22'h0);
        end
    endgenerate

    logic [5:0] thit_idx;
    logic       thit;
    always_comb begin
        thit_idx = 6'h00;
        thit     = 1'b0;
        for (int i = TLBN - 1; i >= 0; i--) begin
            if (tmatch[i]) begin
                thit_idx = 6'(i);
                thit     = 1'b1;
            end
        end
    end

    // Domain check of the hit entry against the domain access register
    logic [21:0] hattr;
    logic [1:0]  dacc;
    logic        dom_fault;
    logic        prot_fault;
    always_comb begin
        hattr = tattr[thit_idx];
        dacc  = 2'b00;
        for (int d = 0; d < 16; d++) begin
            if (hattr[6 + d]) begin
                dacc = dac_r[2*d +: 2];
            end
        end
        dom_fault  = thit & (dacc == 2'b00);
        prot_fault = thit & (dacc == 2'b01) & (ap_decode(hattr[3:0]) == 2'b00);
    end

    // =========================================================================
    // Cache victim pointer; index steps after every tag or data beat
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cidx_r  <= 6'h00;
            cseg_r  <= 2'h0;
            cword_r <= 3'h0;
        end else if (c_victim) begin
            cidx_r  <= req.wdata[31:C_IDX_LSB];
            cseg_r  <= wseg_c;
            cword_r <= wword_c;
        end else if (c_cam | c_ram) begin
            cidx_r  <= cidx_r + 6'h01;
        end
    end

    // Free-running replacement shift register, bit 6 visible on tag reads
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            replacement_shift_register_r <= REPLACEMENT_SHIFT_REGISTER_RST;
        end else begin
            replacement_shift_register_r <= {replacement_shift_register_r[5:0], replacement_shift_register_r[6] ^ replacement_shift_register_r[5]};
        end
    end

    // Cache tag and data arrays are memories, so they carry no reset
    always_ff @(posedge clk) begin
        if (c_cam & req.wr) begin
            ctag[cent] <= {wtag_c, wseg_c};
        end
        if (c_ram & req.wr) begin
            cdata[cdi] <= req.wdata;
        end
    end

    // Cache flag vectors; bulk operations ignore the data written
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cvalid_r <= '0;
            cde_r    <= '0;
            cdo_r    <= '0;
            cwb_r    <= '0;
        end else if (c_inv_all) begin
            cvalid_r <= '0;
        end else if (c_dirty) begin
            cde_r    <= '1;
            cdo_r    <= '1;
        end else if (c_inv_one) begin
            if (chit) begin
                cvalid_r[{wseg_c, chit_idx}] <= 1'b0;
            end
        end else if (c_cam & req.wr) begin
            cvalid_r[cent] <= req.wdata[C_VAL_BIT];
            cde_r[cent]    <= req.wdata[C_DE_BIT];
            cdo_r[cent]    <= req.wdata[C_DO_BIT];
            cwb_r[cent]    <= req.wdata[C_WB_BIT];
        end
    end

    // Cache match result, held for the read that follows the write
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cmres_r <= 32'h0000_0000;
        end else if (c_match & req.wr) begin
            cmres_r <= {~chit, chit,
                        cdata[{wseg_c, chit_idx, wword_c}][29:0]};
        end
    end

    // =========================================================================
    // Translation index; the physical index trails by one access
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tidx_r     <= 6'h00;
            tidx2_r    <= 6'h00;
            pair_sel_r <= 1'b0;
        end else begin
            if (t_lock & req.wr) begin
                tidx_r  <= req.wdata[31:T_IDX_LSB];
            end else if (t_cam | attr_acc) begin
                tidx_r  <= tidx_r + 6'h01;
                tidx2_r <= tidx_r;
            end
            if (t_pair) begin
                pair_sel_r <= ~pair_sel_r;
            end else if (acc) begin
                pair_sel_r <= 1'b0;
            end
        end
    end

    // Translation arrays; size codes are stored as written, each in its own code
    always_ff @(posedge clk) begin
        if (t_cam & req.wr) begin
            ttag[tidx_r]  <= wtag_t;
            tsize[tidx_r] <= req.wdata[T_TAG_LSB-1:T_SIZE_LSB];
        end
        if (attr_acc & req.wr) begin
            tattr[tidx_r] <= req.wdata[21:0];
        end
        if (phys_acc & req.wr) begin
            tphys[tidx2_r] <= req.wdata[31:T_SIZE_LSB];
        end
    end

    // Translation valid and preserved flags; preserved entries survive bulk clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tvalid_r <= '0;
            tpres_r  <= '0;
        end else if (t_inv_all) begin
            tvalid_r <= tvalid_r & tpres_r;
        end else if (t_inv_one) begin
            tvalid_r <= tvalid_r & ~tmatch;
        end else if (t_cam & req.wr) begin
            tvalid_r[tidx_r] <= req.wdata[T_VAL_BIT];
            tpres_r[tidx_r]  <= req.wdata[T_PRES_BIT];
        end
    end

    // Domain access and lockdown registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dac_r  <= DAC_RST;
            lock_r <= LOCK_RST;
        end else begin
            if (t_dac & req.wr) begin
                dac_r <= req.wdata;
            end
            if (t_lock & req.wr) begin
                lock_r <= req.wdata & LOCK_MASK;
            end
        end
    end

    // Translation match result; fault bits only change on a match
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tmres_r  <= 32'h0000_0000;
            tfault_r <= 3'h0;
        end else if (t_match & req.wr) begin
            tfault_r <= {prot_fault, dom_fault, ~thit};
            tmres_r  <= {7'h00, prot_fault, dom_fault, ~thit,
                         thit ? hattr : 22'h000000};
        end
    end

    // =========================================================================
    // Read data selection
    always_comb begin
        resp_nxt.rvalid = req.rd & legal;
        resp_nxt.err    = acc & ~legal;
        resp_nxt.rdata  = 32'h0000_0000;
        if (req.rd) begin
            if (c_cam) begin
                resp_nxt.rdata = {ctag[cent][26:2], ctag[cent][1], 1'b0, cvalid_r[cent],
                                  cde_r[cent], cdo_r[cent], cwb_r[cent],
                                  replacement_shift_register_r[6]};
            end else if (c_ram) begin
                resp_nxt.rdata = cdata[cdi];
            end else if (c_match) begin
                resp_nxt.rdata = cmres_r;
            end else if (t_match) begin
                resp_nxt.rdata = tmres_r;
            end else if (t_cam) begin
                resp_nxt.rdata = {ttag[tidx_r], tsize[tidx_r], tvalid_r[tidx_r],
                                  tpres_r[tidx_r], 4'h0};
            end else if (attr_acc) begin
                resp_nxt.rdata = {7'h00, tfault_r, tattr[tidx_r]};
            end else if (phys_acc) begin
                resp_nxt.rdata = {tphys[tidx2_r], 6'h00};
            end else if (t_dac) begin
                resp_nxt.rdata = dac_r;
            end else if (t_lock) begin
                resp_nxt.rdata = lock_r;
            end
        end
    end

    // Answer register; read data and flags appear one cycle after the request
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            resp_r <= '0;
        end else begin
            resp_r <= resp_nxt;
        end
    end

    assign resp = resp_r;

endmodule

/* File: include/cache_tlb_test_pkg.sv */
// Constants, types and layouts for the cache and translation array test access block
// =============================================================================
// Contract
// - Cache mode decodes tag, data, match, invalidate, dirty, victim
// - Tag CACHE_TAG_CAM_PORT word layout, read bits 6,5,0 special
// - Cache match write carries tag, segment, word
// - Match read returns miss, hit, data bits 29:0
// - Invalidate-by-address clears the one matching entry
// - Victim pointer takes index, segment and word fields
// - Victim pointer selects entry for later accesses
// - Cache index increments after each CACHE_TAG_CAM_PORT/RAM access
// - Whole tag segment covered by 64-beat burst
// - Translation mode decodes its nine test locations
// - Translation invalidate and match carry tag 31:10
// - Translation CACHE_TAG_CAM_PORT layout: tag, size, valid, preserved
// - CACHE_TAG_CAM_PORT size codes for 1MB down to 1KB
// - Attribute array layout: faults, domains, flags, permission
// - Fault bits meaningful only after a match lookup
// - One-hot permission bits decode to two-bit permission
// - Physical array layout: tag and size code
// - Physical size code swaps 4KB and 1KB codes; the code stores it unswapped, as written
// - Translation index increments after CACHE_TAG_CAM_PORT/attribute access
// - Physical array index lags by one access
// - Burst address is location plus burst base
package cache_tlb_test_pkg;

    // =========================================================================
    // Array geometry
    localparam int unsigned CSEG  = 4;
    localparam int unsigned CLINE = 64;
    localparam int unsigned CWORD = 8;
    localparam int unsigned TLBN  = 64;

    // =========================================================================
    // Location offsets (low six address bits), burst base in bits 8:6
    localparam logic [5:0] LOC_C_CAM     = 6'h04;
    localparam logic [5:0] LOC_C_RAM     = 6'h08;
    localparam logic [5:0] LOC_C_MATCH   = 6'h0c;
    localparam logic [5:0] LOC_C_INV_ALL = 6'h10;
    localparam logic [5:0] LOC_C_DIRTY   = 6'h14;
    localparam logic [5:0] LOC_C_VICTIM  = 6'h18;
    localparam logic [5:0] LOC_C_INV_ONE = 6'h1c;
    localparam logic [5:0] LOC_T_INV_ONE = 6'h04;
    localparam logic [5:0] LOC_T_MATCH   = 6'h08;
    localparam logic [5:0] LOC_T_CAM     = 6'h24;
    localparam logic [5:0] LOC_T_ATTR    = 6'h28;
    localparam logic [5:0] LOC_T_PHYS    = 6'h2c;
    localparam logic [5:0] LOC_T_PAIR    = 6'h30;
    localparam logic [5:0] LOC_T_DAC     = 6'h34;
    localparam logic [5:0] LOC_T_LOCK    = 6'h38;
    localparam logic [5:0] LOC_T_INV_ALL = 6'h3c;
    localparam int unsigned ADDR_W       = 9;
    localparam int unsigned BURST_LSB    = 6;

    // =========================================================================
    // Field positions
    localparam int unsigned C_TAG_LSB  = 7;
    localparam int unsigned C_SEG_LSB  = 5;
    localparam int unsigned C_WORD_LSB = 2;
    localparam int unsigned C_IDX_LSB  = 26;
    localparam int unsigned C_VAL_BIT  = 4;
    localparam int unsigned C_DE_BIT   = 3;
    localparam int unsigned C_DO_BIT   = 2;
    localparam int unsigned C_WB_BIT   = 1;
    localparam int unsigned T_TAG_LSB  = 10;
    localparam int unsigned T_SIZE_LSB = 6;
    localparam int unsigned T_VAL_BIT  = 5;
    localparam int unsigned T_PRES_BIT = 4;
    localparam int unsigned T_IDX_LSB  = 26;
    localparam logic [31:0] LOCK_MASK  = 32'hfff0_0001;

    // =========================================================================
    // Reset values
    localparam logic [6:0]  REPLACEMENT_SHIFT_REGISTER_RST = 7'h01;
    localparam logic [31:0] DAC_RST  = 32'h0000_0000;
    localparam logic [31:0] LOCK_RST = 32'h0000_0000;

    // =========================================================================
    // Types
    typedef enum logic [1:0] {MODE_OFF, MODE_CACHE, MODE_TLB} test_mode_e;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
    } tb_req_s;

    typedef struct packed {
        logic        rvalid;
        logic        err;
        logic [31:0] rdata;
    } tb_resp_s;

endpackage

/* File: tb/cache_tlb_test_monitor.sv */
// Concurrent checks on the test bus answer of the array test access block
module cache_tlb_test_monitor (
    // Clock and reset
    input wire logic                          clk,
    input wire logic                          rstn,
    // Watched ports
    input wire cache_tlb_test_pkg::test_mode_e mode,
    input wire cache_tlb_test_pkg::tb_req_s    req,
    input wire cache_tlb_test_pkg::tb_resp_s   resp
);
    timeunit 1ns;
    timeprecision 1ps;
    import cache_tlb_test_pkg::*;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // =========================================================================
    // Single-beat read of one location, burst base zero
    sequence s_rd(test_mode_e m, logic [5:0] loc);
        req.rd && mode == m && req.addr == {3'h0, loc};
    endsequence

    sequence s_any;
        req.wr || req.rd;
    endsequence

    // =========================================================================
    // Answer timing and refusals
    a_off_refused: assert property (s_any ##0 mode == MODE_OFF |=> resp.err && !resp.rvalid)
        else $error("access in mode off not refused");
    a_read_answered: assert property (s_rd(MODE_CACHE, LOC_C_CAM) |=> resp.rvalid && !resp.err)
        else $error("cache tag read not answered");
    a_write_silent: assert property (req.wr && mode != MODE_OFF |=> !resp.rvalid)
        else $error("write gave read data");
    a_idle_zero: assert property (!resp.rvalid |-> resp.rdata == 32'h0)
        else $error("read data outside answer");
    a_wo_refused: assert property (s_rd(MODE_CACHE, LOC_C_INV_ALL) |=> resp.err)
        else $error("read of write-only location accepted");
    a_nonburst_err: assert property (req.wr && mode == MODE_CACHE &&
        req.addr == {3'h1, LOC_C_VICTIM} |=> resp.err)
        else $error("burst to non-burst location accepted");
    // Fixed-zero fields of the read formats
    a_cam_bit5: assert property (s_rd(MODE_CACHE, LOC_C_CAM) |=> resp.rdata[5] == 1'b0)
        else $error("tag read bit 5 not zero");
    a_phys_low: assert property (s_rd(MODE_TLB, LOC_T_PHYS) |=> resp.rdata[5:0] == 6'h0)
        else $error("physical read low bits not zero");
    a_tcam_low: assert property (s_rd(MODE_TLB, LOC_T_CAM) |=> resp.rdata[3:0] == 4'h0)
        else $error("translation tag read low bits not zero");
    a_attr_top: assert property (s_rd(MODE_TLB, LOC_T_ATTR) |=> resp.rdata[31:25] == 7'h0)
        else $error("attribute read top bits not zero");
endmodule

bind cache_tlb_array_test_access cache_tlb_test_monitor i_cache_tlb_test_monitor (
    .clk  (clk),
    .rstn (rstn),
    .mode (mode),
    .req  (req),
    .resp (resp)
);

/* File: tb/test_bus_master.sv */
// Model of the test bus controller that issues one beat per request
module test_bus_master (
    // Clock
    input wire logic                        clk,
    // Bus
    input wire cache_tlb_test_pkg::tb_resp_s resp,
    output     cache_tlb_test_pkg::tb_req_s  req
);
    timeunit 1ns;
    timeprecision 1ps;
    import cache_tlb_test_pkg::*;

    initial req = '0;

    // One beat: request held for its taken edge, answer read mid-cycle while it stands.
    // Released lines show the inverse so stale values never look valid.
    task automatic xfer(input logic w, input logic [8:0] a, input logic [31:0] d,
                        output tb_resp_s r);
        @(posedge clk);
        req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        @(negedge clk);
        r = resp;
    endtask
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the array test access block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cache_tlb_test_pkg::*;

    localparam logic [31:0] CMASK = 32'hffff_fffe; // Bit 0 follows the free shift register
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    test_mode_e mode = MODE_OFF;
    tb_req_s    req;
    tb_resp_s   resp;
    int         failures = 0;
    int         n_compared = 0;
    int         cycles = 0;

    always #12.5 clk = ~clk;

    cache_tlb_array_test_access i_cache_tlb_array_test_access (
        .clk (clk), .rstn (rstn), .mode (mode), .req (req), .resp (resp));
    test_bus_master i_test_bus_master (.clk (clk), .resp (resp), .req (req));

    // =========================================================================
    // Shared bus tasks
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        tb_resp_s r;
        i_test_bus_master.xfer(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [8:0] a, input logic [31:0] m, input logic [31:0] e);
        tb_resp_s r;
        i_test_bus_master.xfer(1'b0, a, 32'h0, r);
        n_compared++;
        if (r.rvalid !== 1'b1 || (r.rdata & m) !== e) begin
            failures++;
            $display("CHECK FAILED at %0t: read %h gave %h", $time, a, r.rdata);
        end
    endtask

    task automatic refuse(input test_mode_e m, input logic w, input logic [8:0] a);
        tb_resp_s r;
        @(posedge clk) mode <= m;
        i_test_bus_master.xfer(w, a, 32'h0, r);
        n_compared++;
        if (r.err !== 1'b1 || r.rdata !== 32'h0) begin
            failures++;
            $display("CHECK FAILED at %0t: access %h not refused", $time, a);
        end
    endtask

    // =========================================================================
    // Scenarios
    task automatic cache_tag_walk;
        @(posedge clk) mode <= MODE_CACHE;
        wr(9'h018, 32'h1400_0040);
        wr(9'h044, 32'h1357_9bda);
        wr(9'h044, 32'h2468_acd0);
        wr(9'h018, 32'h1400_0040);
        rd(9'h044, CMASK, 32'h1357_9bda);
        rd(9'h044, CMASK, 32'h2468_acd0);
        wr(9'h014, 32'h0);
        wr(9'h018, 32'h1400_0040);
        rd(9'h004, CMASK, 32'h1357_9bde);
        // Bulk clear must drop valid whatever data rides with it
        wr(9'h010, 32'hffff_ffff);
        wr(9'h018, 32'h1400_0040);
        rd(9'h004, CMASK, 32'h1357_9bce);
    endtask

    task automatic cache_match;
        wr(9'h018, 32'h2400_002c);
        wr(9'h004, 32'h7654_32b0);
        wr(9'h018, 32'h2400_002c);
        wr(9'h008, 32'hdead_beef);
        wr(9'h018, 32'h2400_002c);
        rd(9'h008, 32'hffff_ffff, 32'hdead_beef);
        wr(9'h00c, 32'h7654_32ac);
        rd(9'h00c, 32'hffff_ffff, 32'h5ead_beef);
        wr(9'h01c, 32'h7654_32a0);
        wr(9'h00c, 32'h7654_32ac);
        rd(9'h00c, 32'hc000_0000, 32'h8000_0000);
    endtask

    task automatic refusals;
        refuse(MODE_OFF, 1'b0, 9'h004);
        refuse(MODE_CACHE, 1'b0, 9'h010);
        refuse(MODE_CACHE, 1'b1, 9'h058);
        refuse(MODE_CACHE, 1'b1, 9'h020);
        refuse(MODE_TLB, 1'b0, 9'h03c);
        refuse(MODE_TLB, 1'b1, 9'h074);
    endtask

    // Entry 3 filled through tag, paired and lagged ports; faults follow the domain
    task automatic tlb_walk;
        @(posedge clk) mode <= MODE_TLB;
        rd(9'h038, 32'hffff_ffff, LOCK_RST);
        rd(9'h034, 32'hffff_ffff, DAC_RST);
        wr(9'h038, 32'h0c0f_ff01);
        rd(9'h038, 32'hffff_ffff, 32'h0c00_0001);
        wr(9'h024, 32'habcd_0460);
        wr(9'h038, 32'h0c0f_ff01);
        wr(9'h030, 32'h0000_0041);
        wr(9'h030, 32'h1234_5440);
        wr(9'h008, 32'habcd_0400);
        rd(9'h008, 32'hffff_ffff, 32'h0080_0041);
        wr(9'h034, 32'h0000_0001);
        wr(9'h008, 32'habcd_0400);
        rd(9'h008, 32'hffff_ffff, 32'h0100_0041);
        wr(9'h038, 32'h0c0f_ff01);
        rd(9'h024, 32'hffff_ffff, 32'habcd_0460);
        wr(9'h038, 32'h0c0f_ff01);
        rd(9'h028, 32'hffff_ffff, 32'h0100_0041);
        rd(9'h02c, 32'hffff_ffff, 32'h1234_5440);
        wr(9'h004, 32'habcd_0400);
        wr(9'h008, 32'habcd_0400);
        rd(9'h008, 32'h0040_0000, 32'h0040_0000);
        // Refill entry 3 unpreserved, prove it hits, then bulk clear must miss
        wr(9'h038, 32'h0c0f_ff01);
        wr(9'h024, 32'habcd_0460);
        wr(9'h008, 32'habcd_0400);
        rd(9'h008, 32'h0040_0000, 32'h0000_0000);
        wr(9'h03c, 32'hffff_ffff);
        wr(9'h008, 32'habcd_0400);
        rd(9'h008, 32'h0040_0000, 32'h0040_0000);
    endtask

    // =========================================================================
    // Verdict and hang guard
    task automatic print_verdict;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Run is about 125 cycles, so this ceiling only trips on a hang
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            print_verdict();
        end
    end

    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        cache_tag_walk();
        cache_match();
        refusals();
        tlb_walk();
        print_verdict();
    end
endmodule
